// ---- rtl/agc_pkg.sv ----
package agc_pkg;

  // ==========================================================
  // widths and coefficient select codes
  // ==========================================================
  localparam int SMP_W = 16;
  localparam int ACC_W = 20;
  localparam logic [1:0] SEL_TX = 2'h0;
  localparam logic [1:0] SEL_RX = 2'h1;
  localparam logic [1:0] SEL_VOL = 2'h2;
  localparam logic [1:0] SEL_ST = 2'h3;

  // ==========================================================
  // audio_mode_reg_one bit positions
  // ==========================================================
  localparam int MODE_TX_BIT = 1;
  localparam int MODE_RX_BIT = 2;
  localparam int MODE_VOL_BIT = 3;

  // ==========================================================
  // coefficient codes and field positions
  // ==========================================================
  localparam logic [15:0] COEF_TX_RST = 16'h0808;
  localparam logic [15:0] COEF_RX_RST = 16'h0808;
  localparam logic [15:0] COEF_VOL_RST = 16'h0099;
  localparam logic [15:0] COEF_ST_RST = 16'h8b7c;
  localparam logic [3:0][15:0] COEF_RST = {COEF_ST_RST, COEF_VOL_RST,
                                           COEF_RX_RST, COEF_TX_RST};
  localparam logic [15:0] COEF_VOL_NULL = 16'h0008;
  localparam logic [15:0] COEF_NULL = 16'h9008;
  // each nibble is {sign, shift[2:0]}; nibble i sits at 4*i
  localparam int NIB_W = 4;

  // ==========================================================
  // saturation limits
  // ==========================================================
  localparam logic signed [15:0] FS_POS = 16'sh7fff;
  localparam logic signed [15:0] FS_NEG = -16'sh8000;

  typedef enum logic {PH_LOW, PH_HIGH} agc_phase_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] sel;
    logic [7:0] data;
  } agc_cfg_req_t;

  typedef struct packed {
    logic vld;
    logic signed [15:0] tx;
    logic signed [15:0] rx;
    logic signed [15:0] tone;
  } agc_smp_t;

endpackage

// ---- rtl/agc_sat_add.sv ----
module agc_sat_add (
  input wire logic signed [15:0] a,
  input wire logic signed [15:0] b,
  output logic signed [15:0] sum
);

  logic signed [16:0] wide;

  // ==========================================================
  // adder that holds at full scale instead of wrapping
  // ==========================================================
  always_comb begin
    wide = 17'(a) + 17'(b);
    if (wide > 17'(agc_pkg::FS_POS)) begin
      sum = agc_pkg::FS_POS;
    end else if (wide < 17'(agc_pkg::FS_NEG)) begin
      sum = agc_pkg::FS_NEG;
    end else begin
      sum = wide[15:0];
    end
  end

endmodule

// ---- rtl/agc_gain_stage.sv ----
module agc_gain_stage #(
  parameter logic [15:0] NULL_CODE = agc_pkg::COEF_NULL
) (
  input wire logic en,
  input wire logic [15:0] coef,
  input wire logic signed [15:0] smp,
  output logic signed [15:0] res
);

  logic signed [19:0] x;
  logic signed [19:0] v0;
  logic signed [19:0] v1;
  logic signed [19:0] v2;
  logic signed [19:0] v3;

  function automatic logic signed [19:0] scl(input logic signed [19:0] a,
                                             input logic [3:0] nib);
    logic signed [19:0] sh;
    sh = a >>> nib[2:0];
    scl = nib[3] ? -sh : sh;
  endfunction

  // ==========================================================
  // shift-and-add multiply: A3(1+A2(1+A1(1+A0))) times sample
  // ==========================================================
  // the shift-and-add form never reaches zero on the null codes, so
  // the mute code is decoded on its own and wins over the product
  always_comb begin
    x = 20'(smp);
    v0 = x + scl(x, coef[3:0]);
    v1 = x + scl(v0, coef[7:4]); // R5 R6 R7 R8 R9
    v2 = x + scl(v1, coef[11:8]);
    v3 = scl(v2, coef[15:12]);
    if (!en) begin
      res = smp; // R15
    end else if (coef == NULL_CODE) begin
      res = 16'sh0000; // R3 R4
    end else if (v3 > 20'(agc_pkg::FS_POS)) begin
      res = agc_pkg::FS_POS; // R18
    end else if (v3 < 20'(agc_pkg::FS_NEG)) begin
      res = agc_pkg::FS_NEG; // R18
    end else begin
      res = v3[15:0];
    end
  end

endmodule

// ---- rtl/agc_gain_top.sv ----
// Overview of operation
// R1: four coefficients, sixteen bits, two bytes each
// R2: bytes move low first, then high
// R3: volume code 0008 enabled gives silence
// R4: code 9008 on other stages gives silence
// R5: volume stage realises its gain table
// R6: transmit stage realises its gain table
// R7: receive stage realises its gain table
// R8: sidetone stage realises its gain table
// R9: tabulated gains accurate to 0.1 dB
// R10: overflow after any stage clips at full scale
// R11: software keeps path below full scale
// R12: full-scale tone fills transmit path, no headroom
// R13: software keeps combined tones below full scale
// R14: software limits summed receive path level
// R15: mode bits select coefficient or 0 dB bypass
// R16: sidetone feeds scaled transmit into receive
// R17: new coefficient applies only after both bytes
// R18: gain multiplies saturate instead of wrapping
module agc_gain_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] audio_mode_reg_one,
  input wire agc_pkg::agc_cfg_req_t cfg_req,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvld,
  input wire agc_pkg::agc_smp_t smp_in,
  output logic signed [15:0] tx_out,
  output logic signed [15:0] rx_out,
  output logic smp_out_vld
);

  // ==========================================================
  // coefficient storage
  // ==========================================================
  logic [15:0] coef_q [4];
  logic [15:0] coef_d [4];
  logic [7:0] shadow_q [4];
  logic [7:0] shadow_d [4];
  agc_pkg::agc_phase_t wph_q [4];
  agc_pkg::agc_phase_t wph_d [4];
  agc_pkg::agc_phase_t rph_q [4];
  agc_pkg::agc_phase_t rph_d [4];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvld_q;
  logic rvld_d;

  // low byte waits in a shadow so samples never see half a code
  // each code keeps its own write and read phase, so accesses to different
  // codes may interleave without one losing the other's place
  always_comb begin
    coef_d = coef_q;
    shadow_d = shadow_q;
    wph_d = wph_q;
    rph_d = rph_q;
    rdata_d = rdata_q;
    rvld_d = 1'b0;
    if (cfg_req.wr) begin
      if (wph_q[cfg_req.sel] == agc_pkg::PH_LOW) begin
        shadow_d[cfg_req.sel] = cfg_req.data; // R2
        wph_d[cfg_req.sel] = agc_pkg::PH_HIGH;
      end else begin
        coef_d[cfg_req.sel] = {cfg_req.data, shadow_q[cfg_req.sel]}; // R1 R17
        wph_d[cfg_req.sel] = agc_pkg::PH_LOW;
      end
    end
    if (cfg_req.rd) begin
      rvld_d = 1'b1;
      if (rph_q[cfg_req.sel] == agc_pkg::PH_LOW) begin
        rdata_d = coef_q[cfg_req.sel][7:0]; // R2
        rph_d[cfg_req.sel] = agc_pkg::PH_HIGH;
      end else begin
        rdata_d = coef_q[cfg_req.sel][15:8];
        rph_d[cfg_req.sel] = agc_pkg::PH_LOW;
      end
    end
  end

  // codes come back to their idle values so the sidetone starts at about -1.2 dB, phase inverted
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        coef_q[i] <= agc_pkg::COEF_RST[i];
        shadow_q[i] <= 8'h00;
        wph_q[i] <= agc_pkg::PH_LOW;
        rph_q[i] <= agc_pkg::PH_LOW;
      end
      rdata_q <= 8'h00;
      rvld_q <= 1'b0;
    end else begin
      coef_q <= coef_d;
      shadow_q <= shadow_d;
      wph_q <= wph_d;
      rph_q <= rph_d;
      rdata_q <= rdata_d;
      rvld_q <= rvld_d;
    end
  end

  assign cfg_rdata = rdata_q;
  assign cfg_rvld = rvld_q;

  // ==========================================================
  // sample path
  // ==========================================================
  logic signed [15:0] tx_gx;
  logic signed [15:0] tx_sum;
  logic signed [15:0] rx_gr;
  logic signed [15:0] rx_ger;
  logic signed [15:0] rx_st;
  logic signed [15:0] rx_sum;
  logic signed [15:0] tx_q;
  logic signed [15:0] tx_d;
  logic signed [15:0] rx_q;
  logic signed [15:0] rx_d;
  logic vld_q;
  logic vld_d;

  agc_gain_stage #(
    .NULL_CODE(agc_pkg::COEF_NULL)
  ) u_tx_gain (
    .en(audio_mode_reg_one[agc_pkg::MODE_TX_BIT]),
    .coef(coef_q[agc_pkg::SEL_TX]),
    .smp(smp_in.tx),
    .res(tx_gx)
  );

  // a 0 dB tone alone already reaches full scale; the adder clips the rest
  agc_sat_add u_tx_tone (
    .a(tx_gx),
    .b(smp_in.tone),
    .sum(tx_sum)
  );

  agc_gain_stage #(
    .NULL_CODE(agc_pkg::COEF_NULL)
  ) u_rx_gain (
    .en(audio_mode_reg_one[agc_pkg::MODE_RX_BIT]),
    .coef(coef_q[agc_pkg::SEL_RX]),
    .smp(smp_in.rx),
    .res(rx_gr)
  );

  // clipping here is final: no later stage can recover it
  agc_gain_stage #(
    .NULL_CODE(agc_pkg::COEF_VOL_NULL)
  ) u_vol_gain (
    .en(audio_mode_reg_one[agc_pkg::MODE_VOL_BIT]),
    .coef(coef_q[agc_pkg::SEL_VOL]),
    .smp(rx_gr),
    .res(rx_ger)
  );

  // sidetone has no bypass bit; it always uses its code
  agc_gain_stage #(
    .NULL_CODE(agc_pkg::COEF_NULL)
  ) u_st_gain (
    .en(1'b1),
    .coef(coef_q[agc_pkg::SEL_ST]),
    .smp(tx_sum),
    .res(rx_st)
  );

  agc_sat_add u_rx_mix (
    .a(rx_ger),
    .b(rx_st),
    .sum(rx_sum)
  );

  // outputs hold between strobes; a consumer that samples late still sees
  // the last result rather than one computed from a half-changed input
  always_comb begin
    tx_d = tx_q;
    rx_d = rx_q;
    vld_d = smp_in.vld;
    if (smp_in.vld) begin
      tx_d = tx_sum; // R12 R10
      rx_d = rx_sum; // R16 R10
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_q <= 16'sh0000;
      rx_q <= 16'sh0000;
      vld_q <= 1'b0;
    end else begin
      tx_q <= tx_d;
      rx_q <= rx_d;
      vld_q <= vld_d;
    end
  end

  assign tx_out = tx_q;
  assign rx_out = rx_q;
  assign smp_out_vld = vld_q;

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // the combinational checks guard the stage outputs directly, so a wrong
  // decode shows up even on cycles without a sample strobe

  chk_hi_commit: assert property ( // R17
    cfg_req.wr && cfg_req.sel == agc_pkg::SEL_TX && wph_q[0] == agc_pkg::PH_HIGH
    |=> coef_q[0] == {$past(cfg_req.data), $past(shadow_q[0])})
    else $error("transmit code not committed on high byte");

  chk_lo_hold: assert property ( // R2
    cfg_req.wr && cfg_req.sel == agc_pkg::SEL_ST && wph_q[3] == agc_pkg::PH_LOW
    |=> $stable(coef_q[3]) && wph_q[3] == agc_pkg::PH_HIGH)
    else $error("sidetone code changed on low byte");

  chk_rd_order: assert property ( // R2
    cfg_req.rd && cfg_req.sel == agc_pkg::SEL_RX && rph_q[1] == agc_pkg::PH_LOW
    && !cfg_req.wr
    |=> cfg_rvld && cfg_rdata == $past(coef_q[1][7:0])
    ##0 rph_q[1] == agc_pkg::PH_HIGH)
    else $error("low byte not returned first");

  chk_vol_null: assert property ( // R3
    audio_mode_reg_one[agc_pkg::MODE_VOL_BIT]
    && coef_q[2] == agc_pkg::COEF_VOL_NULL |-> rx_ger == 16'sh0000)
    else $error("volume null code not silent");

  chk_tx_null: assert property ( // R4
    smp_in.vld && audio_mode_reg_one[agc_pkg::MODE_TX_BIT]
    && coef_q[0] == agc_pkg::COEF_NULL && smp_in.tone == 16'sh0000
    |=> tx_out == 16'sh0000 && smp_out_vld)
    else $error("transmit null code not silent");

  chk_tx_bypass: assert property ( // R15
    smp_in.vld && !audio_mode_reg_one[agc_pkg::MODE_TX_BIT]
    && smp_in.tone == 16'sh0000 |=> tx_out == $past(smp_in.tx))
    else $error("bypassed transmit stage changed sample");

  chk_st_null: assert property ( // R16
    smp_in.vld && coef_q[3] == agc_pkg::COEF_NULL
    |=> rx_out == $past(rx_ger))
    else $error("muted sidetone leaked into receive");

  chk_no_wrap: assert property ( // R10
    smp_in.vld && rx_ger >= 16'sh0000 && rx_st >= 16'sh0000
    |=> rx_out >= 16'sh0000)
    else $error("receive mix wrapped negative");

  chk_out_vld: assert property ( // R16
    smp_in.vld |=> smp_out_vld ##1 (smp_out_vld == $past(smp_in.vld)))
    else $error("output strobe out of step with input");

  chk_hold_idle: assert property ( // R10
    !smp_in.vld |=> $stable(tx_out) && $stable(rx_out) && !smp_out_vld)
    else $error("outputs moved without a sample");

  chk_rx_null: assert property ( // R4
    audio_mode_reg_one[agc_pkg::MODE_RX_BIT] && coef_q[1] == agc_pkg::COEF_NULL
    |-> rx_gr == 16'sh0000)
    else $error("receive null code not silent");

  chk_st_mute: assert property ( // R4
    coef_q[3] == agc_pkg::COEF_NULL |-> rx_st == 16'sh0000)
    else $error("sidetone null code not silent");

  chk_rx_bypass: assert property ( // R15
    !audio_mode_reg_one[agc_pkg::MODE_RX_BIT] |-> rx_gr == smp_in.rx)
    else $error("bypassed receive stage changed sample");

  chk_vol_bypass: assert property ( // R15
    !audio_mode_reg_one[agc_pkg::MODE_VOL_BIT] |-> rx_ger == rx_gr)
    else $error("bypassed volume stage changed sample");

  chk_tone_full: assert property ( // R12
    smp_in.vld && smp_in.tone == agc_pkg::FS_POS && tx_gx >= 16'sh0000
    |=> tx_out == agc_pkg::FS_POS)
    else $error("full-scale tone did not fill transmit path");

  chk_rd_high: assert property ( // R2
    cfg_req.rd && !cfg_req.wr && cfg_req.sel == agc_pkg::SEL_VOL
    && rph_q[2] == agc_pkg::PH_HIGH
    |=> cfg_rvld && cfg_rdata == $past(coef_q[2][15:8]))
    else $error("high byte not returned second");

  chk_rx_lo_hold: assert property ( // R17
    cfg_req.wr && cfg_req.sel == agc_pkg::SEL_RX && wph_q[1] == agc_pkg::PH_LOW
    |=> $stable(coef_q[1]))
    else $error("receive code changed on low byte");

  chk_vol_commit: assert property ( // R17
    cfg_req.wr && cfg_req.sel == agc_pkg::SEL_VOL && wph_q[2] == agc_pkg::PH_HIGH
    |=> coef_q[2] == {$past(cfg_req.data), $past(shadow_q[2])})
    else $error("volume code not committed on high byte");

  chk_rvld_pulse: assert property ( // R2
    !cfg_req.rd |=> !cfg_rvld)
    else $error("read strobe without a read");

  chk_st_path: assert property ( // R16
    smp_in.vld && rx_ger == 16'sh0000 |=> rx_out == $past(rx_st))
    else $error("sidetone not carried into receive");

endmodule

// ---- tb/agc_cpu_model.sv ----
module agc_cpu_model (
  input wire logic clk_sys,
  output agc_pkg::agc_cfg_req_t cfg_req,
  input wire logic [7:0] cfg_rdata,
  input wire logic cfg_rvld
);
  timeunit 1ns;
  timeprecision 1ns;

  initial cfg_req = '0;

  // ==========================================================
  // byte cycles
  // ==========================================================
  // released data bus shows the inverse so a stale byte is never mistaken for a live one
  task automatic wr_byte(input logic [1:0] sel, input logic [7:0] d);
    @(posedge clk_sys);
    cfg_req <= '{wr: 1'b1, rd: 1'b0, sel: sel, data: d};
    @(posedge clk_sys);
    cfg_req <= '{wr: 1'b0, rd: 1'b0, sel: sel, data: ~d};
  endtask

  task automatic rd_byte(input logic [1:0] sel, output logic [7:0] d);
    @(posedge clk_sys);
    cfg_req <= '{wr: 1'b0, rd: 1'b1, sel: sel, data: 8'h00};
    @(posedge clk_sys);
    cfg_req <= '{wr: 1'b0, rd: 1'b0, sel: sel, data: 8'hff};
    #1;
    d = (cfg_rvld === 1'b1) ? cfg_rdata : 8'hxx;
  endtask

  // ==========================================================
  // whole coefficients, low byte first
  // ==========================================================
  task automatic wr_coef(input logic [1:0] sel, input logic [15:0] c);
    wr_byte(sel, c[7:0]);
    wr_byte(sel, c[15:8]);
  endtask

  task automatic rd_coef(input logic [1:0] sel, output logic [15:0] c);
    rd_byte(sel, c[7:0]);
    rd_byte(sel, c[15:8]);
  endtask
endmodule

// ---- tb/agc_gain_top_tb.sv ----
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("ERROR t=%0t got %h exp %h", $time, (got), (exp)); end end

module agc_gain_top_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] mode = 8'h00;
  agc_pkg::agc_cfg_req_t cfg_req;
  agc_pkg::agc_smp_t smp_in = '0;
  logic [7:0] cfg_rdata;
  logic cfg_rvld;
  logic signed [15:0] tx_out;
  logic signed [15:0] rx_out;
  logic smp_out_vld;
  logic [15:0] c;
  int error_cnt = 0;
  int total_checks = 0;

  always #50 clk_sys = ~clk_sys;

  agc_gain_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .audio_mode_reg_one(mode),
    .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvld(cfg_rvld), .smp_in(smp_in),
    .tx_out(tx_out), .rx_out(rx_out), .smp_out_vld(smp_out_vld));

  agc_cpu_model u_cpu (.clk_sys(clk_sys), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_rvld(cfg_rvld));

  // ==========================================================
  // shared tasks
  // ==========================================================
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic set_mode(input logic [7:0] m);
    @(posedge clk_sys);
    mode <= m;
  endtask

  task automatic send(input logic signed [15:0] tx, rx, tone, etx, erx);
    @(posedge clk_sys);
    smp_in <= '{vld: 1'b1, tx: tx, rx: rx, tone: tone};
    @(posedge clk_sys);
    smp_in.vld <= 1'b0;
    #1;
    `CHK(smp_out_vld, 1'b1)
    `CHK(tx_out, etx)
    `CHK(rx_out, erx)
  endtask

  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_reset_read;
    for (int s = 0; s < 4; s++) begin
      u_cpu.rd_coef(2'(s), c);
      `CHK(c, agc_pkg::COEF_RST[s])
    end
  endtask

  // sidetone muted first so the receive output shows only the receive stages
  task automatic t_bypass_clip;
    set_mode(8'h00);
    u_cpu.wr_coef(agc_pkg::SEL_ST, agc_pkg::COEF_NULL);
    send(16'h0100, 16'h0200, 16'h0010, 16'h0110, 16'h0200);
    send(16'h7000, 16'h0000, 16'h7000, agc_pkg::FS_POS, 16'h0000);
    send(16'h0001, 16'h0000, 16'h7fff, agc_pkg::FS_POS, 16'h0000);
    send(16'h9000, 16'h0000, 16'h9000, agc_pkg::FS_NEG, 16'h0000);
  endtask

  task automatic t_tx_gain;
    set_mode(8'h02);
    u_cpu.wr_coef(agc_pkg::SEL_TX, 16'h0000);
    send(16'h0100, 16'h0000, 16'h0000, 16'h0400, 16'h0000);
    send(16'h3000, 16'h0000, 16'h0000, agc_pkg::FS_POS, 16'h0000);
    send(16'hd000, 16'h0000, 16'h0000, agc_pkg::FS_NEG, 16'h0000);
    u_cpu.wr_byte(agc_pkg::SEL_TX, 8'h11);
    send(16'h0100, 16'h0000, 16'h0000, 16'h0400, 16'h0000);
    u_cpu.rd_coef(agc_pkg::SEL_TX, c);
    `CHK(c, 16'h0000)
    u_cpu.wr_byte(agc_pkg::SEL_TX, 8'h11);
    send(16'h0100, 16'h0000, 16'h0000, 16'h00f0, 16'h0000);
    u_cpu.wr_coef(agc_pkg::SEL_TX, agc_pkg::COEF_NULL);
    send(16'h0100, 16'h0000, 16'h0020, 16'h0020, 16'h0000);
  endtask

  // x4 then 0.9375: a clipped 7fff after the first stage ends at 77ff, not 7fff
  task automatic t_rx_path;
    set_mode(8'h04);
    u_cpu.wr_coef(agc_pkg::SEL_RX, 16'h1111);
    send(16'h0000, 16'h0100, 16'h0000, 16'h0000, 16'h00f0);
    u_cpu.wr_coef(agc_pkg::SEL_RX, agc_pkg::COEF_NULL);
    send(16'h0000, 16'h0100, 16'h0000, 16'h0000, 16'h0000);
    set_mode(8'h08);
    u_cpu.wr_coef(agc_pkg::SEL_VOL, 16'h0000);
    send(16'h0000, 16'h0100, 16'h0000, 16'h0000, 16'h0400);
    u_cpu.wr_coef(agc_pkg::SEL_VOL, agc_pkg::COEF_VOL_NULL);
    send(16'h0000, 16'h0100, 16'h0000, 16'h0000, 16'h0000);
    set_mode(8'h0c);
    u_cpu.wr_coef(agc_pkg::SEL_RX, 16'h0000);
    u_cpu.wr_coef(agc_pkg::SEL_VOL, 16'h1111);
    send(16'h0000, 16'h3000, 16'h0000, 16'h0000, 16'h77ff);
  endtask

  // sidetone at 0.9375 mixes into receive; the last sample overflows the mix and clips at full scale
  task automatic t_sidetone;
    set_mode(8'h00);
    u_cpu.wr_coef(agc_pkg::SEL_ST, 16'h1111);
    send(16'h0100, 16'h0000, 16'h0000, 16'h0100, 16'h00f0);
    send(16'h0100, 16'h0010, 16'h0000, 16'h0100, 16'h0100);
    send(16'h7000, 16'h7000, 16'h0000, 16'h7000, agc_pkg::FS_POS);
  endtask

  // reset mid-run drops a pending low byte and restores the idle codes
  task automatic t_mid_reset;
    u_cpu.wr_byte(agc_pkg::SEL_RX, 8'h55);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(tx_out, 16'h0000)
    `CHK(rx_out, 16'h0000)
    @(posedge clk_sys);
    rst_n <= 1'b1;
    u_cpu.rd_coef(agc_pkg::SEL_ST, c);
    `CHK(c, agc_pkg::COEF_ST_RST)
    u_cpu.wr_coef(agc_pkg::SEL_RX, 16'h1111);
    u_cpu.rd_coef(agc_pkg::SEL_RX, c);
    `CHK(c, 16'h1111)
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    #1;
    `CHK(smp_out_vld, 1'b0)
    `CHK(cfg_rvld, 1'b0)
    @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset_read();
    t_bypass_clip();
    t_tx_gain();
    t_rx_path();
    t_sidetone();
    t_mid_reset();
    finish_test();
  end

  // all scenarios need well under 1000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    finish_test();
  end
endmodule
